// ---- pcur_overlay.sv ----
// palette RAM host ports, scratch words and hardware cursor overlay
// assumes strobes are synchronous to i_clk_sys; panel timing supplies position
`timescale 1ns/1ps
module pcur_overlay (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [pcur_pkg::ADDR_W-1:0] i_addr,
	input wire logic [15:0] i_sd,
	output logic [15:0] o_sd,
	output logic o_sd_oe,
	output logic o_rdy,
	input wire logic i_line_start,
	input wire logic [4:0] i_cur_line,
	input wire logic i_pix_valid,
	input wire logic [15:0] i_pix_data,
	input wire logic i_cur_hit,
	input wire logic [4:0] i_cur_x,
	output logic o_pix_valid,
	output logic [17:0] o_pix_color,
	output logic o_pix_direct,
	output logic o_fm_req,
	output logic [pcur_pkg::FM_AW-1:0] o_fm_addr,
	input wire logic i_fm_ack,
	input wire logic [15:0] i_fm_data
);
	import pcur_pkg::*;

	// 18-bit entries stored as {red, green, blue}
	logic [17:0] pal [0:255];
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic [11:0] rg_stage;
	logic [15:0] scratch_a;
	logic [15:0] scratch_b;
	logic [2:0] mode_bpp;
	logic [7:0] cur_ctrl;
	logic [15:0] col0a;
	logic [15:0] col0b;
	logic [15:0] col1a;
	logic [15:0] col1b;
	logic acc_d;
	logic active;
	logic acc_start;
	logic wr_take;
	logic rd_take;
	logic [17:0] rd_entry;
	logic cur_en;
	logic p0;
	logic p1;
	logic act;
	logic direct;
	logic [7:0] mask;
	logic valid_a;
	logic direct_a;
	logic use_reg_a;
	logic [7:0] idx_a;
	logic [17:0] reg_col_a;
	logic [15:0] word_a;

	pcur_fetch_if fif ();

	// palette index built from the cursor colour register pair
	function automatic logic [7:0] col_index(input logic [15:0] a, input logic [15:0] b);
		col_index = {a[2:0], b[5:1]};
	endfunction

	// direct colour from the register pair, red/green word plus blue word
	function automatic logic [17:0] col_rgb(input logic [15:0] a, input logic [15:0] b);
		col_rgb = {a[RED_LSB+CH_W-1:RED_LSB], a[GREEN_LSB+CH_W-1:GREEN_LSB], b[5:0]};
	endfunction

	// highest reachable index for each indexed depth
	function automatic logic [7:0] max_index(input logic [2:0] bpp);
		unique case (bpp)
			PCUR_BPP_1: max_index = 8'h01;
			PCUR_BPP_2: max_index = 8'h03;
			PCUR_BPP_4: max_index = 8'h0F;
			PCUR_BPP_5: max_index = 8'h1F;
			PCUR_BPP_6: max_index = 8'h3F;
			default: max_index = 8'hFF;
		endcase
	endfunction

	// one access is taken on the first cycle of each strobe
	assign active = !i_cs_n && (!i_rd_n || !i_wr_n);
	assign acc_start = active && !acc_d;
	assign wr_take = acc_start && !i_wr_n;
	assign rd_take = acc_start && !i_rd_n && i_wr_n;
	assign rd_entry = pal[rd_idx];

	// strobe edge tracking and ready handshake
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			acc_d <= 1'b0;
			o_rdy <= 1'b1;
			o_sd_oe <= 1'b0;
		end else begin
			acc_d <= active;
			o_rdy <= !acc_start;
			o_sd_oe <= !i_cs_n && !i_rd_n;
		end
	end

	// control and scratch registers
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wr_idx <= 8'h00;
			rd_idx <= 8'h00;
			rg_stage <= 12'h000;
			scratch_a <= RESET_WORD;
			scratch_b <= RESET_WORD;
			mode_bpp <= PCUR_BPP_1;
			cur_ctrl <= CUR_OFF;
			col0a <= RESET_WORD;
			col0b <= RESET_WORD;
			col1a <= RESET_WORD;
			col1b <= RESET_WORD;
		end else if (wr_take) begin
			unique case (i_addr)
				OFS_PAL_WR_IDX: wr_idx <= i_sd[7:0];
				OFS_PAL_RG_WR: rg_stage <= {i_sd[13:8], i_sd[5:0]};
				OFS_PAL_RD_IDX: rd_idx <= i_sd[7:0];
				OFS_SCRATCH_A: scratch_a <= i_sd;
				OFS_SCRATCH_B: scratch_b <= i_sd;
				OFS_MODE: mode_bpp <= i_sd[2:0];
				OFS_CUR_CTRL: cur_ctrl <= i_sd[7:0];
				OFS_COL0A: col0a <= i_sd & 16'h3F3F;
				OFS_COL0B: col0b <= i_sd & 16'h003F;
				OFS_COL1A: col1a <= i_sd & 16'h3F3F;
				OFS_COL1B: col1b <= i_sd & 16'h003F;
				default: ;
			endcase
		end
	end

	// palette write port: staged red/green lands with blue in one write
	always_ff @(posedge i_clk_sys) begin
		if (wr_take && i_addr == OFS_PAL_B_WR) begin
			pal[wr_idx] <= {rg_stage, i_sd[5:0]};
		end
	end

	// read data; write-only ports and holes read as zero
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_sd <= RESET_WORD;
		end else if (rd_take) begin
			unique case (i_addr)
				OFS_PAL_RG_RD: o_sd <= {2'h0, rd_entry[17:12], 2'h0, rd_entry[11:6]};
				OFS_PAL_B_RD: o_sd <= {10'h000, rd_entry[5:0]};
				OFS_SCRATCH_A: o_sd <= scratch_a;
				OFS_SCRATCH_B: o_sd <= scratch_b;
				OFS_MODE: o_sd <= {13'h0000, mode_bpp};
				OFS_CUR_CTRL: o_sd <= {8'h00, cur_ctrl};
				OFS_COL0A: o_sd <= col0a;
				OFS_COL0B: o_sd <= col0b;
				OFS_COL1A: o_sd <= col1a;
				OFS_COL1B: o_sd <= col1b;
				default: o_sd <= RESET_WORD;
			endcase
		end
	end

	// line fetcher hookup; a line fetched mid-line replaces planes at once,
	// so the timing side should start it during horizontal blanking
	assign fif.start = i_line_start && cur_en;
	assign fif.line_y = i_cur_line;
	assign fif.pat_sel = (cur_ctrl == CUR_PAT1);
	assign fif.fm_ack = i_fm_ack;
	assign fif.fm_data = i_fm_data;
	assign o_fm_req = fif.fm_req;
	assign o_fm_addr = fif.fm_addr;

	pcur_line_fetch u_fetch (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.fif(fif)
	);

	// overlay decision; other control codes also keep the cursor hidden
	assign cur_en = (cur_ctrl == CUR_PAT0) || (cur_ctrl == CUR_PAT1);
	assign p0 = fif.plane0[i_cur_x];
	assign p1 = fif.plane1[i_cur_x];
	assign act = cur_en && i_cur_hit;
	assign direct = (mode_bpp == PCUR_BPP_16);
	assign mask = max_index(mode_bpp);

	// stage A: pick index or direct value per pixel
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			valid_a <= 1'b0;
			direct_a <= 1'b0;
			use_reg_a <= 1'b0;
			idx_a <= 8'h00;
			reg_col_a <= 18'h00000;
			word_a <= 16'h0000;
		end else begin
			valid_a <= i_pix_valid;
			direct_a <= direct;
			use_reg_a <= 1'b0;
			idx_a <= i_pix_data[7:0] & mask;
			reg_col_a <= 18'h00000;
			word_a <= i_pix_data;
			if (act) begin
				unique case ({p0, p1})
					2'b00: begin
						use_reg_a <= direct;
						reg_col_a <= col_rgb(col0a, col0b);
						idx_a <= col_index(col0a, col0b);
					end
					2'b10: begin
						use_reg_a <= direct;
						reg_col_a <= col_rgb(col1a, col1b);
						idx_a <= col_index(col1a, col1b);
					end
					2'b01: ;
					2'b11: begin
						idx_a <= ~i_pix_data[7:0] & mask;
						word_a <= ~i_pix_data;
					end
				endcase
			end
		end
	end

	// stage B: palette lookup or direct pass, all from flops
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pix_valid <= 1'b0;
			o_pix_direct <= 1'b0;
			o_pix_color <= 18'h00000;
		end else begin
			o_pix_valid <= valid_a;
			o_pix_direct <= direct_a;
			if (!direct_a) begin
				o_pix_color <= pal[idx_a];
			end else if (use_reg_a) begin
				o_pix_color <= reg_col_a;
			end else begin
				o_pix_color <= {2'h0, word_a};
			end
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	// host access and pixel steps used by the checks below
	sequence s_wr(logic [7:0] ofs);
		wr_take && i_addr == ofs;
	endsequence
	sequence s_cur(logic [1:0] pp);
		i_pix_valid && act && {p0, p1} == pp;
	endsequence
	// cursor pixel while an indexed depth is selected
	sequence s_idx(logic [1:0] pp);
		s_cur(pp) ##0 !direct;
	endsequence

	// host port checks, one edge after the access is taken
	AST_WR_INDEX: assert property (
		s_wr(OFS_PAL_WR_IDX) |=> wr_idx == $past(i_sd[7:0]))
		else $error("write index not stored");
	AST_RG_STAGE: assert property (
		s_wr(OFS_PAL_RG_WR) |=> rg_stage == $past({i_sd[13:8], i_sd[5:0]}))
		else $error("red/green staging wrong");
	AST_BLUE_COMMIT: assert property (
		s_wr(OFS_PAL_B_WR) |=> pal[$past(wr_idx)] == {$past(rg_stage), $past(i_sd[5:0])})
		else $error("palette entry not committed whole");
	AST_RD_INDEX: assert property (
		s_wr(OFS_PAL_RD_IDX) |=> rd_idx == $past(i_sd[7:0]))
		else $error("read index not stored");
	AST_RD_RG: assert property (
		rd_take && i_addr == OFS_PAL_RG_RD |=>
		o_sd == {2'h0, $past(rd_entry[17:12]), 2'h0, $past(rd_entry[11:6])} && !o_rdy)
		else $error("red/green read wrong");
	AST_RD_B: assert property (
		rd_take && i_addr == OFS_PAL_B_RD |=> o_sd == {10'h000, $past(rd_entry[5:0])})
		else $error("blue read wrong");
	AST_WO_READ: assert property (
		rd_take && i_addr == OFS_PAL_RG_WR |=> o_sd == RESET_WORD)
		else $error("write-only port read not zero");
	AST_SCRATCH: assert property (
		s_wr(OFS_SCRATCH_B) |=> scratch_b == $past(i_sd))
		else $error("scratch word not stored");
	AST_SCRATCH_RD: assert property (
		rd_take && i_addr == OFS_SCRATCH_A |=> o_sd == $past(scratch_a))
		else $error("scratch word not returned");

	// line fetch and pixel path checks; stage A one edge on, output two edges on
	AST_LINE_DONE: assert property (
		fif.done |-> $past(o_fm_req) && $past(i_fm_ack))
		else $error("line done without its last word");
	AST_TRANSPARENT: assert property (
		s_idx(2'b01) |=> idx_a == ($past(i_pix_data[7:0]) & $past(mask)))
		else $error("transparent pixel altered");
	AST_COL1_INDEX: assert property (
		s_idx(2'b10) |=> idx_a == {$past(col1a[2:0]), $past(col1b[5:1])})
		else $error("colour 1 index wrong");
	AST_INV_IDX: assert property (
		s_idx(2'b11) |=> idx_a == ($past(~i_pix_data[7:0]) & $past(mask)))
		else $error("inverted index wrong");
	AST_INV_WORD: assert property (
		s_cur(2'b11) ##0 direct |-> ##2 o_pix_color == {2'h0, ~$past(i_pix_data, 2)})
		else $error("direct invert wrong");
	AST_COL0_DIRECT: assert property (
		s_cur(2'b00) ##0 direct |-> ##2 o_pix_color == $past(col_rgb(col0a, col0b), 2))
		else $error("direct colour 0 wrong");
	AST_COL1_DIRECT: assert property (
		s_cur(2'b10) ##0 direct |-> ##2
		o_pix_color == {$past(col1a[13:8], 2), $past(col1a[5:0], 2), $past(col1b[5:0], 2)})
		else $error("direct colour 1 wrong");
	AST_OFF_PASS: assert property (
		i_pix_valid && cur_ctrl == CUR_OFF && direct |-> ##2
		o_pix_valid && o_pix_color == {2'h0, $past(i_pix_data, 2)})
		else $error("disabled cursor altered pixel");
	AST_MASK_4BPP: assert property (
		s_idx(2'b11) ##0 mode_bpp == PCUR_BPP_4 |=> idx_a[7:4] == 4'h0)
		else $error("index above depth limit");
endmodule

// ---- pcur_pkg.sv ----
// palette port and cursor overlay: shared constants, offsets and encodings
// assumes a 16-bit register bus with byte offsets and a 2 MB frame memory
package pcur_pkg;
	localparam int ADDR_W = 8;
	localparam int FM_AW = 21;
	localparam logic [7:0] OFS_MODE = 8'h02;
	localparam logic [7:0] OFS_CUR_CTRL = 8'h20;
	localparam logic [7:0] OFS_COL0A = 8'h26;
	localparam logic [7:0] OFS_COL0B = 8'h28;
	localparam logic [7:0] OFS_COL1A = 8'h2A;
	localparam logic [7:0] OFS_COL1B = 8'h2C;
	localparam logic [7:0] OFS_PAL_WR_IDX = 8'h40;
	localparam logic [7:0] OFS_PAL_RG_WR = 8'h42;
	localparam logic [7:0] OFS_PAL_B_WR = 8'h44;
	localparam logic [7:0] OFS_PAL_RD_IDX = 8'h46;
	localparam logic [7:0] OFS_PAL_RG_RD = 8'h48;
	localparam logic [7:0] OFS_PAL_B_RD = 8'h4A;
	localparam logic [7:0] OFS_SCRATCH_A = 8'h50;
	localparam logic [7:0] OFS_SCRATCH_B = 8'h52;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam int RED_LSB = 8;
	localparam int GREEN_LSB = 0;
	localparam int CH_W = 6;
	localparam logic [7:0] CUR_OFF = 8'h00;
	localparam logic [7:0] CUR_PAT0 = 8'h01;
	localparam logic [7:0] CUR_PAT1 = 8'h05;
	localparam logic [20:0] PAT0_BASE = 21'h1FFE00;
	localparam logic [20:0] PAT1_BASE = 21'h1FFF00;
	localparam logic [1:0] LAST_WORD = 2'h3;
	typedef enum logic [2:0] {
		PCUR_BPP_1 = 3'h0,
		PCUR_BPP_2 = 3'h1,
		PCUR_BPP_4 = 3'h2,
		PCUR_BPP_5 = 3'h3,
		PCUR_BPP_6 = 3'h4,
		PCUR_BPP_8 = 3'h5,
		PCUR_BPP_16 = 3'h6
	} pcur_bpp_t;
	typedef enum logic [2:0] {
		PCUR_F_IDLE = 3'b001,
		PCUR_F_ISSUE = 3'b010,
		PCUR_F_WAIT = 3'b100
	} pcur_fstate_t;
endpackage

// ---- pcur_fetch_if.sv ----
// link between overlay core and its cursor line fetcher
// assumes both ends share i_clk_sys
`timescale 1ns/1ps
interface pcur_fetch_if;
	logic start;
	logic [4:0] line_y;
	logic pat_sel;
	logic fm_req;
	logic [20:0] fm_addr;
	logic fm_ack;
	logic [15:0] fm_data;
	logic [31:0] plane0;
	logic [31:0] plane1;
	logic done;
	modport fetcher (input start, line_y, pat_sel, fm_ack, fm_data,
		output fm_req, fm_addr, plane0, plane1, done);
	modport owner (output start, line_y, pat_sel, fm_ack, fm_data,
		input fm_req, fm_addr, plane0, plane1, done);
endinterface

// ---- pcur_line_fetch.sv ----
// fetches one cursor scan line (two 32-bit planes) from frame memory
// assumes memory answers each held request with a one-cycle ack plus data
`timescale 1ns/1ps
module pcur_line_fetch (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	pcur_fetch_if.fetcher fif
);
	import pcur_pkg::*;
	pcur_fstate_t state;
	logic [1:0] wcnt;
	logic [20:0] line_base;
	logic [15:0] w0;
	logic [15:0] w1;
	logic [15:0] w2;

	// request/ack sequencer, four words per line
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state <= PCUR_F_IDLE;
			wcnt <= 2'h0;
			line_base <= 21'h000000;
			fif.fm_req <= 1'b0;
			fif.fm_addr <= 21'h000000;
			fif.done <= 1'b0;
		end else begin
			fif.done <= 1'b0;
			unique case (state)
				PCUR_F_IDLE: begin
					if (fif.start) begin
						// eight bytes per line from the pattern start
						line_base <= (fif.pat_sel ? PAT1_BASE : PAT0_BASE)
							+ {13'h0000, fif.line_y, 3'h0};
						wcnt <= 2'h0;
						state <= PCUR_F_ISSUE;
					end
				end
				PCUR_F_ISSUE: begin
					fif.fm_req <= 1'b1;
					fif.fm_addr <= line_base + {18'h00000, wcnt, 1'b0};
					state <= PCUR_F_WAIT;
				end
				PCUR_F_WAIT: begin
					if (fif.fm_ack) begin
						fif.fm_req <= 1'b0;
						wcnt <= wcnt + 2'h1;
						if (wcnt == LAST_WORD) begin
							fif.done <= 1'b1;
							state <= PCUR_F_IDLE;
						end else begin
							state <= PCUR_F_ISSUE;
						end
					end
				end
			endcase
		end
	end

	// word capture; low address byte is the low byte, pixel x is bit x
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			w0 <= 16'h0000;
			w1 <= 16'h0000;
			w2 <= 16'h0000;
			fif.plane0 <= 32'h00000000;
			fif.plane1 <= 32'h00000000;
		end else if (state == PCUR_F_WAIT && fif.fm_ack) begin
			unique case (wcnt)
				2'h0: w0 <= fif.fm_data;
				2'h1: w1 <= fif.fm_data;
				2'h2: w2 <= fif.fm_data;
				2'h3: begin
					fif.plane0 <= {w1, w0};
					fif.plane1 <= {fif.fm_data, w2};
				end
			endcase
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	AST_FETCH_TOP: assert property ($rose(fif.fm_req) |-> fif.fm_addr[20:9] == 12'hFFF)
		else $error("cursor fetch outside top 512 bytes");
	AST_FETCH_STEP: assert property ($rose(fif.fm_req) && state == PCUR_F_WAIT && wcnt == 2'h1
		|-> fif.fm_addr == line_base + 21'h000002)
		else $error("cursor fetch word order wrong");
endmodule

// ---- pcur_fm_model.sv ----
// frame memory stand-in that answers the cursor pattern word reads
// assumes the overlay holds each request until it sees the ack
`timescale 1ns/1ps
module pcur_fm_model (
	input wire logic i_clk_sys,
	input wire logic i_req,
	input wire logic [20:0] i_addr,
	output logic o_ack,
	output logic [15:0] o_data
);
	int lat;
	// content follows from the address so the bench can predict planes
	function automatic logic [15:0] word_at(input logic [20:0] a);
		return a[15:0] * 16'h9E37 ^ 16'hC3A5;
	endfunction
	initial begin
		o_ack = 1'b0;
		o_data = 16'hA5A5;
		lat = 0;
	end
	// latency 1..3 cycles; data flips when not valid so stale words never match
	always @(posedge i_clk_sys) begin
		o_ack <= 1'b0;
		o_data <= ~o_data;
		if (i_req && !o_ack) begin
			if (lat == 0) begin
				o_ack <= 1'b1;
				o_data <= word_at(i_addr);
				lat <= $urandom_range(2, 0);
			end else begin
				lat <= lat - 1;
			end
		end
	end
endmodule

// ---- pcur_overlay_tb.sv ----
// self-checking bench for the palette ports and cursor overlay
// assumes the register strobes and pixel inputs are driven at falling edges
`timescale 1ns/1ps
module pcur_overlay_tb;
	import pcur_pkg::*;
	logic clk, rst, cs_n, rd_n, wr_n, lstart, pv, hit, fm_ack, sd_oe, rdy, opv, odir, fm_req;
	logic [7:0] addr, ctl, msk;
	logic [15:0] wd, sd, pdata, fm_data, rdv, v, u;
	logic [4:0] line, cx;
	logic [17:0] ocol;
	logic [20:0] fm_addr, a;
	logic [2:0] bpp;
	logic [17:0] pal [256];
	logic [19:0] ex [32];
	logic [15:0] ca [2];
	logic [15:0] cb [2];
	logic [31:0] pl0, pl1;
	int fail_count, total_checks, k, j, mi, t, nk;

	pcur_overlay pcur_overlay_inst (.i_clk_sys(clk), .i_reset(rst), .i_cs_n(cs_n),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr), .i_sd(wd), .o_sd(sd),
		.o_sd_oe(sd_oe), .o_rdy(rdy), .i_line_start(lstart), .i_cur_line(line),
		.i_pix_valid(pv), .i_pix_data(pdata), .i_cur_hit(hit), .i_cur_x(cx),
		.o_pix_valid(opv), .o_pix_color(ocol), .o_pix_direct(odir), .o_fm_req(fm_req),
		.o_fm_addr(fm_addr), .i_fm_ack(fm_ack), .i_fm_data(fm_data));
	pcur_fm_model pcur_fm_model_inst (.i_clk_sys(clk), .i_req(fm_req), .i_addr(fm_addr),
		.o_ack(fm_ack), .o_data(fm_data));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic final_report();
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one access; strobes held until ready is seen high again
	task automatic bus(input logic w, input logic [7:0] ad, input logic [15:0] d);
		int n;
		@(negedge clk);
		cs_n = 1'b0;
		wr_n = !w;
		rd_n = w;
		addr = ad;
		wd = d;
		n = 0;
		@(posedge clk);
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 8);
		if (rdy !== 1'b1) begin
			fail_count++;
			final_report();
		end
		rdv = sd;
		cmp(sd_oe, !w);
		@(negedge clk);
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [15:0] e);
		bus(1'b0, ad, 16'h0000);
		cmp(rdv, e);
	endtask

	// frame memory content, same formula the partner model answers with
	function automatic logic [15:0] fm_word(input logic [20:0] ad);
		return ad[15:0] * 16'h9E37 ^ 16'hC3A5;
	endfunction

	// read back one entry through the read index and both read ports
	task automatic pchk(input logic [7:0] i);
		bus(1'b1, OFS_PAL_RD_IDX, {8'h00, i});
		bus(1'b0, OFS_PAL_RG_RD, 16'h0000);
		cmp(rdv & 16'h3F3F, {2'b00, pal[i][17:12], 2'b00, pal[i][11:6]});
		bus(1'b0, OFS_PAL_B_RD, 16'h0000);
		cmp(rdv & 16'h003F, {10'h000, pal[i][5:0]});
	endtask

	function automatic logic [7:0] mask_of(input logic [2:0] b);
		case (b)
			3'h0: return 8'h01;
			3'h1: return 8'h03;
			3'h2: return 8'h0F;
			3'h3: return 8'h1F;
			3'h4: return 8'h3F;
			default: return 8'hFF;
		endcase
	endfunction

	function automatic logic [17:0] col(input int n);
		if (bpp == PCUR_BPP_16) return {ca[n][13:8], ca[n][5:0], cb[n][5:0]};
		return pal[{ca[n][2:0], cb[n][5:1]}];
	endfunction

	// expected {valid, direct, colour} for one pixel
	function automatic logic [19:0] expect_pix(input logic h, input logic [4:0] x,
		input logic [15:0] d);
		logic [17:0] c;
		logic dir;
		dir = (bpp == PCUR_BPP_16);
		c = dir ? {2'b00, d} : pal[d[7:0] & msk];
		if (h && (ctl == CUR_PAT0 || ctl == CUR_PAT1)) begin
			case ({pl1[x], pl0[x]})
				2'b00: c = col(0);
				2'b01: c = col(1);
				2'b11: c = dir ? {2'b00, ~d} : pal[~d[7:0] & msk];
				default: ;
			endcase
		end
		return {1'b1, dir, c};
	endfunction

	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		addr = 8'h00;
		wd = 16'h0000;
		lstart = 1'b0;
		line = 5'h00;
		pv = 1'b0;
		pdata = 16'h0000;
		hit = 1'b0;
		cx = 5'h00;
		rst = 1'b1;
		fail_count = 0;
		total_checks = 0;
		void'($urandom(32'h31a62397));
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rd(OFS_SCRATCH_A, 16'h0000);
		rd(OFS_SCRATCH_B, 16'h0000);
		v = 16'($urandom);
		u = 16'($urandom);
		bus(1'b1, OFS_SCRATCH_A, v);
		bus(1'b1, OFS_SCRATCH_B, u);
		rd(OFS_SCRATCH_A, v);
		rd(OFS_SCRATCH_B, u);
		rd(OFS_PAL_RG_WR, 16'h0000);
		// fill every entry: index, then red/green, then blue
		for (k = 0; k < 256; k++) begin
			v = 16'($urandom);
			u = 16'($urandom);
			bus(1'b1, OFS_PAL_WR_IDX, 16'(k));
			bus(1'b1, OFS_PAL_RG_WR, v);
			bus(1'b1, OFS_PAL_B_WR, u);
			pal[k] = {v[13:8], v[5:0], u[5:0]};
		end
		for (k = 0; k < 10; k++) pchk(k < 2 ? 8'(k * 255) : 8'($urandom));
		// a staged red/green alone must leave the entry as it was
		j = $urandom_range(255, 0);
		v = 16'($urandom);
		u = 16'($urandom);
		bus(1'b1, OFS_PAL_WR_IDX, 16'(j));
		bus(1'b1, OFS_PAL_RG_WR, v);
		pchk(8'(j));
		bus(1'b1, OFS_PAL_B_WR, u);
		pal[j] = {v[13:8], v[5:0], u[5:0]};
		pchk(8'(j));
		// every depth, both patterns, and a final direct pass with the cursor off
		for (mi = 0; mi < 8; mi++) begin
			bpp = (mi == 7) ? PCUR_BPP_16 : 3'(mi);
			ctl = (mi == 7) ? CUR_OFF : (mi[0] ? CUR_PAT1 : CUR_PAT0);
			msk = mask_of(bpp);
			for (j = 0; j < 2; j++) begin
				ca[j] = 16'($urandom) & 16'h3F3F;
				cb[j] = 16'($urandom) & 16'h003F;
				ca[j][2:0] = ca[j][2:0] & msk[7:5];
				cb[j][5:1] = cb[j][5:1] & msk[4:0];
				bus(1'b1, 8'(OFS_COL0A + 4 * j), ca[j]);
				bus(1'b1, 8'(OFS_COL0B + 4 * j), cb[j]);
			end
			bus(1'b1, OFS_MODE, {13'h0000, bpp});
			bus(1'b1, OFS_CUR_CTRL, {8'h00, ctl});
			line = 5'($urandom);
			a = ((ctl == CUR_PAT1) ? PAT1_BASE : PAT0_BASE) + 21'(line) * 21'h8;
			@(negedge clk);
			lstart = 1'b1;
			@(negedge clk);
			lstart = 1'b0;
			nk = 0;
			for (t = 0; t < 80 && nk < 4; t++) begin
				@(posedge clk);
				if (fm_ack === 1'b1) begin
					cmp(fm_addr, a + 21'(2 * nk));
					nk++;
				end
			end
			cmp(21'(nk), (ctl == CUR_OFF) ? 21'h0 : 21'h4);
			// a line that never finished is already counted; stop here
			if (ctl != CUR_OFF && nk < 4) begin
				final_report();
			end
			if (ctl != CUR_OFF) begin
				pl0 = {fm_word(a + 21'h2), fm_word(a)};
				pl1 = {fm_word(a + 21'h6), fm_word(a + 21'h4)};
			end
			// back-to-back pixels, each checked two cycles after it went in
			for (k = 0; k < 34; k++) begin
				@(negedge clk);
				if (k >= 2) cmp({opv, odir, ocol}, ex[k - 2]);
				if (k < 32) begin
					hit = ($urandom_range(3, 0) != 0);
					cx = 5'($urandom);
					pdata = 16'($urandom);
					pv = 1'b1;
					ex[k] = expect_pix(hit, cx, pdata);
				end else begin
					pv = 1'b0;
				end
			end
		end
		final_report();
	end
endmodule
